// ---- common/pdlc_pkg.sv ----
// constants, carriers and helpers for the loop divider and lock control
package pdlc_pkg;

    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_PD = 8'h04;
    localparam logic [7:0] OFF_SYSDIV = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int FBSEL_LSB = 0;
    localparam int FBSEL_W = 5;
    localparam int PSEL_LSB = 5;
    localparam int PSEL_W = 2;
    localparam int PD_BIT = 0;
    localparam int LOCK_BIT = 0;
    localparam int RUN_BIT = 1;
    localparam int SYSDIV_W = 8;
    localparam logic [4:0] FBSEL_RST = 5'h00;
    localparam logic [1:0] PSEL_RST = 2'h0;
    localparam logic PD_RST = 1'b1;
    localparam logic [7:0] SYSDIV_RST = 8'h01;

    // more than eight good reference periods
    localparam logic [3:0] LOCK_GOOD = 4'h9;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // bus carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } pdlc_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pdlc_axi_rsp_t;

    // post divider ratio P from its select field: 1, 2, 4, 8
    function automatic logic [3:0] pdlc_p_ratio(input logic [1:0] psel);
        return 4'h1 << psel;
    endfunction : pdlc_p_ratio

endpackage : pdlc_pkg

// ---- logic/pdlc_top.sv ----
// loop divider, power-down and lock control with its register slave
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module pdlc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire pdlc_pkg::pdlc_axi_req_t axi_req,
    output pdlc_pkg::pdlc_axi_rsp_t axi_rsp,
    input wire logic ref_clk_in,
    input wire logic phase_err_in,
    output logic osc_enable,
    output logic divider_reset,
    output logic post_clk,
    output logic fb_tick,
    output logic sys_tick,
    output logic loop_locked,
    output logic [5:0] fb_ratio,
    output logic [4:0] post_ratio
);
    import pdlc_pkg::*;

    typedef struct packed {
        logic aw_rdy;
        logic aw_got;
        logic [ADDR_W-1:0] aw_addr;
        logic w_rdy;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic ar_rdy;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [4:0] fbsel;
        logic [1:0] psel;
        logic pd;
        logic [7:0] sysdiv;
        logic [2:0] ref_s;
        logic ref_lvl;
        logic [2:0] err_s;
        logic err_lvl;
        logic osc_en;
        logic div_rst;
        logic [3:0] post_cnt;
        logic post_clk;
        logic [4:0] fb_cnt;
        logic fb_tick;
        logic [3:0] lock_cnt;
        logic lock;
        logic [7:0] sys_cnt;
        logic sys_tick;
        logic [5:0] fb_ratio;
        logic [4:0] post_ratio;
    } pdlc_state_t;

    pdlc_state_t s_r;
    pdlc_state_t s_nxt;
    logic do_wr;
    logic ref_rise;
    logic [3:0] p_val;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        do_wr = 1'b0;
        p_val = pdlc_p_ratio(s_r.psel);

        // three-stage pin sampling, change taken when stages 2 and 3 agree
        s_nxt.ref_s = {s_r.ref_s[1:0], ref_clk_in};
        s_nxt.err_s = {s_r.err_s[1:0], phase_err_in};
        if (s_r.ref_s[1] == s_r.ref_s[2])
            s_nxt.ref_lvl = s_r.ref_s[2];
        if (s_r.err_s[1] == s_r.err_s[2])
            s_nxt.err_lvl = s_r.err_s[2];
        ref_rise = (s_r.ref_s[1] == s_r.ref_s[2]) && s_r.ref_s[2]
                   && !s_r.ref_lvl;

        // write channel
        if (axi_req.awvalid && s_r.aw_rdy)
        begin
            s_nxt.aw_got = 1'b1;
            s_nxt.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && s_r.w_rdy)
        begin
            s_nxt.w_got = 1'b1;
            s_nxt.wdata = axi_req.wdata;
            s_nxt.wstrb = axi_req.wstrb;
        end
        if (s_r.bvalid && axi_req.bready)
            s_nxt.bvalid = 1'b0;
        if (s_r.aw_got && s_r.w_got && !s_r.bvalid)
        begin
            do_wr = 1'b1;
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp = RESP_OKAY;
            case (s_r.aw_addr)
                OFF_CTRL:
                    if (s_r.wstrb[0])
                    begin
                        s_nxt.fbsel = s_r.wdata[FBSEL_LSB +: FBSEL_W];
                        s_nxt.psel = s_r.wdata[PSEL_LSB +: PSEL_W];
                    end
                OFF_PD:
                    if (s_r.wstrb[0])
                        s_nxt.pd = s_r.wdata[PD_BIT];
                OFF_SYSDIV:
                    if (s_r.wstrb[0])
                        s_nxt.sysdiv = s_r.wdata[SYSDIV_W-1:0];
                OFF_STATUS: ;
                default: s_nxt.bresp = RESP_SLVERR;
            endcase
        end
        s_nxt.aw_rdy = !s_nxt.aw_got && !s_nxt.bvalid;
        s_nxt.w_rdy = !s_nxt.w_got && !s_nxt.bvalid;

        // read channel
        if (s_r.rvalid && axi_req.rready)
            s_nxt.rvalid = 1'b0;
        if (axi_req.arvalid && s_r.ar_rdy)
        begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp = RESP_OKAY;
            s_nxt.rdata = '0;
            case (axi_req.araddr)
                OFF_CTRL:
                begin
                    s_nxt.rdata[FBSEL_LSB +: FBSEL_W] = s_r.fbsel;
                    s_nxt.rdata[PSEL_LSB +: PSEL_W] = s_r.psel;
                end
                OFF_PD: s_nxt.rdata[PD_BIT] = s_r.pd;
                OFF_SYSDIV: s_nxt.rdata[SYSDIV_W-1:0] = s_r.sysdiv;
                OFF_STATUS:
                begin
                    s_nxt.rdata[LOCK_BIT] = s_r.lock;
                    s_nxt.rdata[RUN_BIT] = s_r.osc_en;
                end
                default: s_nxt.rresp = RESP_SLVERR;
            endcase
        end
        s_nxt.ar_rdy = !s_nxt.rvalid;

        // loop: gated by the power-down value just written
        s_nxt.osc_en = !s_nxt.pd;
        s_nxt.div_rst = s_nxt.pd;
        s_nxt.fb_ratio = {1'b0, s_nxt.fbsel} + 6'h01;
        s_nxt.post_ratio = {pdlc_p_ratio(s_nxt.psel), 1'b0};
        s_nxt.fb_tick = 1'b0;
        if (s_nxt.pd)
        begin
            // dividers held, lock dropped
            s_nxt.post_cnt = '0;
            s_nxt.post_clk = 1'b0;
            s_nxt.fb_cnt = '0;
            s_nxt.lock_cnt = '0;
            s_nxt.lock = 1'b0;
        end
        else
        begin
            // half period of P cycles: 2P total, even duty
            if (s_r.post_cnt >= p_val - 4'h1)
            begin
                s_nxt.post_cnt = '0;
                s_nxt.post_clk = !s_r.post_clk;
                if (!s_r.post_clk)
                begin
                    // feedback divides output by M
                    if (s_r.fb_cnt >= s_r.fbsel)
                    begin
                        s_nxt.fb_cnt = '0;
                        s_nxt.fb_tick = 1'b1;
                    end
                    else
                        s_nxt.fb_cnt = s_r.fb_cnt + 5'h01;
                end
            end
            else
                s_nxt.post_cnt = s_r.post_cnt + 4'h1;

            // lock detector, one measurement per rising reference edge
            if (ref_rise)
            begin
                if (s_r.err_lvl)
                begin
                    s_nxt.lock_cnt = '0;
                    s_nxt.lock = 1'b0;
                end
                else if (s_r.lock_cnt != LOCK_GOOD)
                begin
                    s_nxt.lock_cnt = s_r.lock_cnt + 4'h1;
                    if (s_r.lock_cnt + 4'h1 == LOCK_GOOD)
                        s_nxt.lock = 1'b1;
                end
            end
        end

        // system clock divider, one passes every main cycle
        if (s_r.sysdiv == '0)
        begin
            s_nxt.sys_cnt = '0;
            s_nxt.sys_tick = 1'b0;
        end
        else if (s_r.sys_cnt >= s_r.sysdiv - 8'h01)
        begin
            s_nxt.sys_cnt = '0;
            s_nxt.sys_tick = 1'b1;
        end
        else
        begin
            s_nxt.sys_cnt = s_r.sys_cnt + 8'h01;
            s_nxt.sys_tick = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_r <= '0;
            s_r.aw_rdy <= 1'b1;
            s_r.w_rdy <= 1'b1;
            s_r.ar_rdy <= 1'b1;
            s_r.fbsel <= FBSEL_RST;
            s_r.psel <= PSEL_RST;
            s_r.pd <= PD_RST;
            s_r.div_rst <= PD_RST;
            s_r.sysdiv <= SYSDIV_RST;
            s_r.fb_ratio <= {1'b0, FBSEL_RST} + 6'h01;
            s_r.post_ratio <= {pdlc_p_ratio(PSEL_RST), 1'b0};
        end
        else
            s_r <= s_nxt;
    end

    assign axi_rsp = '{awready: s_r.aw_rdy, wready: s_r.w_rdy,
                       bvalid: s_r.bvalid, bresp: s_r.bresp,
                       arready: s_r.ar_rdy, rvalid: s_r.rvalid,
                       rdata: s_r.rdata, rresp: s_r.rresp};
    assign osc_enable = s_r.osc_en;
    assign divider_reset = s_r.div_rst;
    assign post_clk = s_r.post_clk;
    assign fb_tick = s_r.fb_tick;
    assign sys_tick = s_r.sys_tick;
    assign loop_locked = s_r.lock;
    assign fb_ratio = s_r.fb_ratio;
    assign post_ratio = s_r.post_ratio;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_pd_lock_low: assert property (s_r.pd |-> !loop_locked)
        else $error("lock high during power-down");
    a_pd_dividers_held: assert property (s_r.pd |-> !osc_enable
        && divider_reset && s_r.post_cnt == '0 && !post_clk)
        else $error("dividers not held in power-down");
    a_lock_after_run: assert property ($rose(loop_locked)
        |-> s_r.lock_cnt == LOCK_GOOD && !$past(s_r.err_lvl))
        else $error("lock rose without nine good periods");
    a_err_drops_lock: assert property (ref_rise && s_r.err_lvl
        |=> !loop_locked && s_r.lock_cnt == '0)
        else $error("large error did not drop lock");
    // at least eight more reference edges are needed after release
    a_release_no_lock: assert property ($fell(s_r.pd)
        |-> !loop_locked [*8])
        else $error("lock high right after release");
    // while running, output toggles exactly when P cycles are used up
    a_post_duty: assert property (!s_r.pd
        |-> ($changed(post_clk)
        == ($past(s_r.post_cnt) >= $past(p_val) - 4'h1)))
        else $error("post divider half period wrong");
    a_fb_ratio: assert property (fb_ratio == {1'b0, s_r.fbsel} + 6'h01
        && post_ratio == {pdlc_p_ratio(s_r.psel), 1'b0})
        else $error("divider ratio outputs wrong");
    a_sysdiv_one: assert property (s_r.sysdiv == 8'h01
        |=> sys_tick)
        else $error("divide by one did not pass every cycle");
    a_pd_write: assert property (do_wr && s_r.aw_addr == OFF_PD
        && s_r.wstrb[0] |=> s_r.pd == $past(s_r.wdata[PD_BIT])
        && axi_rsp.bvalid)
        else $error("power-down write not applied");

    c_lock_reached: cover property ($rose(loop_locked));
    c_lock_lost: cover property ($fell(loop_locked) && !s_r.pd);
    c_pd_release: cover property ($fell(s_r.pd));
    c_status_read: cover property (axi_req.arvalid && s_r.ar_rdy
        && axi_req.araddr == OFF_STATUS);

endmodule : pdlc_top

// ---- logic/pdlc_unused_guard.sv ----
// holds no logic; every part of the block sits in pdlc_top

// ---- verification/pdlc_ref_model.sv ----
// reference clock source and phase comparator model
`timescale 1ns/10ps
module pdlc_ref_model #(
    parameter int HALF = 5
) (
    input wire logic aclk,
    input wire logic osc_enable,
    input wire logic err_req,
    output logic ref_clk_in,
    output logic phase_err_in
);
    int cnt = 0;
    logic ref_r = 1'b0;
    // free-running reference, period 2*HALF cycles
    always @(posedge aclk)
    begin
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
        if (cnt == HALF - 1)
            ref_r <= ~ref_r;
    end
    assign ref_clk_in = ref_r;
    // a stopped oscillator reads as a large error
    assign phase_err_in = err_req | ~osc_enable;
endmodule : pdlc_ref_model

// ---- verification/pdlc_top_tb.sv ----
// self-checking bench for the loop divider and lock control
`timescale 1ns/10ps
module pdlc_top_tb;
    import pdlc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic err_req = 1'b0;
    pdlc_axi_req_t req = '0;
    pdlc_axi_rsp_t rsp;
    logic ref_clk_in, phase_err_in, osc_enable, divider_reset;
    logic post_clk, fb_tick, sys_tick, loop_locked;
    logic [5:0] fb_ratio;
    logic [4:0] post_ratio;
    logic [31:0] rd;
    logic [1:0] rs;
    logic [3:0] wst = 4'hF;
    int fail_count = 0;
    int n_compared = 0;
    int k;
    int n;
    int hi;
    int lo;

    always #5 aclk = ~aclk;

    pdlc_top i_dut (.aclk(aclk), .aresetn(aresetn), .axi_req(req),
        .axi_rsp(rsp), .ref_clk_in(ref_clk_in),
        .phase_err_in(phase_err_in), .osc_enable(osc_enable),
        .divider_reset(divider_reset), .post_clk(post_clk),
        .fb_tick(fb_tick), .sys_tick(sys_tick),
        .loop_locked(loop_locked), .fb_ratio(fb_ratio),
        .post_ratio(post_ratio));

    pdlc_ref_model i_ref (.aclk(aclk), .osc_enable(osc_enable),
        .err_req(err_req), .ref_clk_in(ref_clk_in),
        .phase_err_in(phase_err_in));

    // ------------------------------------------------------------
    // bus and checking tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check

    task automatic guard(input int c);
        if (c >= 400)
        begin
            fail_count++;
            $display("mismatch wait expected done seen %0d cycles", c);
            end_sim();
        end
    endtask : guard

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int c;
        logic aw;
        logic w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= wst;
        req.bready <= 1'b1;
        for (c = 0; !(aw && w && rsp.bvalid === 1'b1); c++)
        begin
            @(posedge aclk);
            guard(c);
            if (req.awvalid && rsp.awready === 1'b1)
            begin
                aw = 1'b1;
                req.awvalid <= 1'b0;
            end
            if (req.wvalid && rsp.wready === 1'b1)
            begin
                w = 1'b1;
                req.wvalid <= 1'b0;
            end
        end
        rs = rsp.bresp;
        req.bready <= 1'b0;
    endtask : wr

    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        int c;
        @(posedge aclk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (c = 0; rsp.rvalid !== 1'b1; c++)
        begin
            @(posedge aclk);
            guard(c);
            if (rsp.arready === 1'b1)
                req.arvalid <= 1'b0;
        end
        req.rready <= 1'b0;
        check("rdata", rsp.rdata, e);
        check("rresp", rsp.rresp, er);
    endtask : rchk

    // consecutive cycles that post_clk samples at level v
    task automatic run_len(input logic v, output int c);
        c = 0;
        while (post_clk === v)
        begin
            @(posedge aclk);
            c++;
            guard(c);
        end
    endtask : run_len

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("osc_enable", osc_enable, 0);
        check("divider_reset", divider_reset, 1);
        check("lock", loop_locked, 0);
        rchk(OFF_CTRL, 0, RESP_OKAY);
        rchk(OFF_PD, 1, RESP_OKAY);
        rchk(OFF_SYSDIV, 1, RESP_OKAY);
        rchk(OFF_STATUS, 0, RESP_OKAY);
        rchk(8'h10, 0, RESP_SLVERR);
        wr(8'h10, 32'h0000_00FF);
        check("bresp", rs, RESP_SLVERR);
        wr(OFF_STATUS, 32'h0000_0003);
        check("bresp", rs, RESP_OKAY);
        // byte 0 not enabled: register keeps its value
        wst = 4'hE;
        wr(OFF_SYSDIV, 32'h0000_0005);
        wst = 4'hF;
        check("bresp", rs, RESP_OKAY);
        rchk(OFF_SYSDIV, 1, RESP_OKAY);
        $display("test reset and map done");
        // every post select, dividers changed only in power-down
        for (k = 0; k < 4; k++)
        begin
            wr(OFF_PD, 1);
            wr(OFF_CTRL, 32'(k * 32 + k + 4));
            wr(OFF_PD, 0);
            check("fb_ratio", fb_ratio, k + 5);
            check("post_ratio", post_ratio, 2 << k);
            run_len(1'b1, hi);
            run_len(1'b0, lo);
            run_len(1'b1, hi);
            run_len(1'b0, lo);
            check("post_high", hi, 1 << k);
            check("post_low", lo, 1 << k);
            for (n = 0; fb_tick !== 1'b1; n++)
            begin
                @(posedge aclk);
                guard(n);
            end
            @(posedge aclk);
            for (n = 1; fb_tick !== 1'b1; n++)
            begin
                @(posedge aclk);
                guard(n);
            end
            check("fb_period", n, (k + 5) * (2 << k));
        end
        $display("test dividers done");
        for (k = 1; k < 4; k++)
        begin
            wr(OFF_SYSDIV, k);
            hi = 0;
            repeat (24)
            begin
                @(posedge aclk);
                hi += (sys_tick === 1'b1);
            end
            check("sys_ticks", hi, 24 / k);
        end
        $display("test system divider done");
        rchk(OFF_STATUS, 3, RESP_OKAY);
        err_req <= 1'b1;
        repeat (12) @(posedge aclk);
        err_req <= 1'b0;
        repeat (6) @(posedge aclk);
        check("lock_err", loop_locked, 0);
        wr(OFF_PD, 1);
        check("lock_pd", loop_locked, 0);
        check("osc_pd", osc_enable, 0);
        check("div_rst_pd", divider_reset, 1);
        check("post_pd", post_clk, 0);
        repeat (30) @(posedge aclk);
        check("lock_pd", loop_locked, 0);
        rchk(OFF_STATUS, 0, RESP_OKAY);
        wr(OFF_PD, 0);
        repeat (78) @(posedge aclk);
        check("lock_early", loop_locked, 0);
        for (n = 0; n < 40 && loop_locked !== 1'b1; n++)
            @(posedge aclk);
        check("lock_regain", loop_locked, 1);
        $display("test power-down and lock done");
        // reset in mid-run brings back the power-on state
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("lock_rst", loop_locked, 0);
        check("osc_rst", osc_enable, 0);
        check("fb_ratio_rst", fb_ratio, 1);
        check("post_ratio_rst", post_ratio, 2);
        rchk(OFF_SYSDIV, 1, RESP_OKAY);
        rchk(OFF_STATUS, 0, RESP_OKAY);
        $display("test reset in run done");
        end_sim();
    end
endmodule : pdlc_top_tb
